// ==== bench/wdv_chk.sv ====
// checker on the link between device end and cpu end
// assumes one mclk domain and a parameter set with WDRST_CYC of 4
`timescale 1ns/1ps
`default_nettype none
module wdv_chk import wdv_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wdtInstr,
  input wire logic flagUpd,
  input wire logic [2:0] flagsZsv,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic rdValid,
  input wire logic irqMask,
  input wire logic irqClear,
  input wire logic irqLatched,
  input wire logic irqReq,
  input wire logic cpuReset
);
  // *****
  // link properties
  // *****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // a refresh taken in run answers next cycle with fixed flags
  property p_flags;
    wdtInstr && !cpuReset |=> flagUpd && flagsZsv == WDT_FLAGS_ZSV;
  endproperty
  a_flags: assert property (p_flags)
    else $error("refresh flags missing or wrong");
  property p_flag_cause;
    flagUpd |-> $past(wdtInstr);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("flag update without refresh");
  property p_rd_any;
    regRd && !cpuReset |=> rdValid;
  endproperty
  a_rd_any: assert property (p_rd_any)
    else $error("read not answered");
  // the mode register never shows its settings
  property p_rd_mode;
    regRd && !cpuReset && regAddr == REG_WDM_ADDR |=>
      rdValid && regRdata == WDM_READ_VALUE;
  endproperty
  a_rd_mode: assert property (p_rd_mode)
    else $error("mode register read back data");
  property p_rdv_cause;
    rdValid |-> $past(regRd) && !$past(cpuReset);
  endproperty
  a_rdv_cause: assert property (p_rdv_cause)
    else $error("read valid without read");
  property p_irq_req;
    irqReq == (irqLatched && irqMask);
  endproperty
  a_irq_req: assert property (p_irq_req)
    else $error("request not gated by mask");
  // latch may only drop on clear or when the device resets
  property p_latch_hold;
    irqLatched && !irqClear && !cpuReset |=> irqLatched || cpuReset;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched request lost");
  property p_wd_reset;
    $rose(cpuReset) |-> cpuReset [*4];
  endproperty
  a_wd_reset: assert property (p_wd_reset)
    else $error("cpu reset too short");
  property p_no_answer;
    cpuReset |=> !flagUpd && !rdValid;
  endproperty
  a_no_answer: assert property (p_no_answer)
    else $error("answer while in reset");

  c_refresh: cover property (wdtInstr && !cpuReset);
  c_timeout: cover property ($rose(cpuReset));
  c_irq: cover property (irqReq);
endmodule : wdv_chk
`default_nettype wire

// ==== bench/wdv_tb_top.sv ====
// self-checking bench joining device end and cpu end over the link
// assumes short tap and power-on counts set by parameters below
`timescale 1ns/1ps
`default_nettype none
module wdv_tb_top import wdv_pkg::*;;
  logic mclk = 0, reset = 1, rcOscPin = 0, brownoutPin = 0;
  logic highCmpPin = 0, lowCmpPin = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, s;
  logic pready, pslverr, globalReset, e;
  int err_count = 0, n_checks = 0, cyc = 0;
  wdv_if lk ();
  wdv_device #(.TAP0_TICKS(4), .TAP2_TICKS(16),
    .TAP3_TICKS(32), .POR_TICKS(4), .WDRST_CYC(4)) wdv_device_inst (
    .mclk(mclk), .reset(reset), .rcOscPin(rcOscPin),
    .brownoutPin(brownoutPin), .highCmpPin(highCmpPin),
    .lowCmpPin(lowCmpPin), .globalReset(globalReset), .link(lk));
  wdv_host wdv_host_inst (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
  wdv_chk wdv_chk_inst (.mclk(mclk), .reset(reset),
    .wdtInstr(lk.wdtInstr), .flagUpd(lk.flagUpd), .flagsZsv(lk.flagsZsv),
    .regRd(lk.regRd), .regAddr(lk.regAddr), .regRdata(lk.regRdata),
    .rdValid(lk.rdValid), .irqMask(lk.irqMask), .irqClear(lk.irqClear),
    .irqLatched(lk.irqLatched), .irqReq(lk.irqReq),
    .cpuReset(lk.cpuReset));

  // *****
  // clocks and guard
  // *****
  always #2.5 mclk = ~mclk;
  // rc pin slower than mclk so the synchroniser sees every level
  always begin
    repeat (3) @(posedge mclk);
    rcOscPin <= ~rcOscPin;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  // *****
  // shared tasks
  // *****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // apb transfer; waits on pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    s = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, APB_CMD, {16'h0000, a, d});
    repeat (4) @(posedge mclk);
  endtask : reg_wr
  // device read via command word, result taken from status
  task automatic reg_rd(input logic [7:0] a);
    apb(1, APB_CMD, {16'h0001, a, 8'h00});
    repeat (4) @(posedge mclk);
    apb(0, APB_STAT, 32'h0);
  endtask : reg_rd
  task automatic wait_lvl(input logic lvl, input int lim);
    int i;
    i = 0;
    while (lk.cpuReset !== lvl && i < lim) begin
      @(posedge mclk);
      i++;
    end
    chk(lk.cpuReset, lvl);
  endtask : wait_lvl

  // *****
  // scenarios
  // *****
  // tap 3 with reserved bits set, written inside the window
  task automatic t_tap();
    reg_wr(REG_WDM_ADDR, 8'hf3);
    apb(1, APB_CTRL, 32'h100);
    repeat (100) @(posedge mclk);
    chk(lk.cpuReset, 0);
    wait_lvl(1, 400);
  endtask : t_tap
  // late write ignored; halt freezes count with bit 2 clear
  task automatic t_window();
    wait_lvl(0, 500);
    repeat (130) @(posedge mclk);
    reg_wr(REG_WDM_ADDR, 8'h07);
    apb(1, APB_CTRL, 32'h101);
    repeat (300) @(posedge mclk);
    chk(lk.cpuReset, 0);
    apb(1, APB_CTRL, 32'h000);
    wait_lvl(1, 100);
    wait_lvl(0, 500);
  endtask : t_window
  task automatic t_basic();
    chk(globalReset, 0);
    reg_rd(REG_WDM_ADDR);
    chk(s[7:0], WDM_READ_VALUE);
    reg_rd(REG_VD_ADDR);
    chk(s[7:0], 8'h00);
    apb(0, 12'h0c0, 32'h0);
    chk({e, s}, {1'b1, 32'h0});
  endtask : t_basic
  task automatic t_vd();
    lowCmpPin <= 1;
    reg_wr(REG_VD_ADDR, 8'h01);
    reg_rd(REG_VD_ADDR);
    chk({s[14], s[7:0]}, 9'h001);
    repeat (VD_VALID_CYC + 20) @(posedge mclk);
    reg_rd(REG_VD_ADDR);
    chk(s[14:0], {1'b1, WDT_FLAGS_ZSV, 3'b010, 8'h03});
    apb(1, APB_CTRL, 32'h004);
    apb(0, APB_STAT, 32'h0);
    chk(s[10:9], 2'b11);
    lowCmpPin <= 0;
    highCmpPin <= 1;
    repeat (8) @(posedge mclk);
    apb(1, APB_CTRL, 32'h204);
    reg_rd(REG_VD_ADDR);
    chk(s[10:0], {3'b000, 8'h05});
    // stop asked while detection is on must be withheld
    apb(1, APB_CTRL, 32'h002);
    apb(0, APB_CTRL, 32'h0);
    chk(s, 32'h0000_0002);
    chk(lk.stopMode, 0);
    reg_wr(REG_VD_ADDR, 8'h00);
    chk(lk.stopMode, 1);
    apb(1, APB_CTRL, 32'h000);
  endtask : t_vd
  task automatic t_brownout();
    brownoutPin <= 1;
    repeat (8) @(posedge mclk);
    chk({globalReset, lk.cpuReset}, 2'b11);
    brownoutPin <= 0;
    wait_lvl(0, 500);
    reg_rd(REG_VD_ADDR);
    chk(s[7:0], 8'h00);
  endtask : t_brownout

  task automatic complete_run();
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 0;
    wait_lvl(0, 500);
    t_tap();
    t_window();
    t_basic();
    t_vd();
    t_brownout();
    complete_run();
  end
endmodule : wdv_tb_top
`default_nettype wire

// ==== design/wdv_device.sv ====
// supervisor device end: watchdog, brown-out reset, voltage detection
// assumes rc oscillator and comparators arrive as asynchronous pins
//
// Behaviour
// [RL1] watchdog timeout resets the cpu
// [RL2] first refresh starts, later refreshes restart count
// [RL3] refresh returns zero, sign, overflow flags
// [RL4] counter steps on rc oscillator, not mclk
// [RL5] mode bits 1:0 pick the timeout tap
// [RL6] mode bit 2 keeps counting during halt
// [RL7] mode bit 3 counts during stop, default 1
// [RL8] mode bits 7:4 have no effect
// [RL9] mode writes accepted only in 120-clock window
// [RL10] mode register reads back no settings
// [RL11] option starts watchdog at power-on
// [RL12] brown-out holds reset, then full power-on
// [RL13] detect enable bit 0, cleared by reset
// [RL14] detect flags invalid for 20 us
// [RL15] high flag reflects supply above high threshold
// [RL16] low flag reflects supply below low threshold
// [RL17] low flag latches interrupt request bit
// [RL18] request raises interrupt only when unmasked
// [RL19] software disables detection before stop
// [RL20] no port mode change during low check
// [RL21] enable interrupts before enabling detection
// [RL22] tap timeouts are parameters
// [RL23] watchdog reset reopens the mode window
`timescale 1ns/1ps
`default_nettype none
module wdv_device import wdv_pkg::*; #(
  parameter int TAP0_TICKS = TAP0_RC_TICKS,
  parameter int TAP1_TICKS = TAP1_RC_TICKS,
  parameter int TAP2_TICKS = TAP2_RC_TICKS,
  parameter int TAP3_TICKS = TAP3_RC_TICKS,
  parameter int POR_TICKS = POR_RC_TICKS,
  parameter int WDRST_CYC = WDRST_CYCLES,
  parameter bit WDT_AT_POR = 1'b0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic rcOscPin,
  input wire logic brownoutPin,
  input wire logic highCmpPin,
  input wire logic lowCmpPin,
  output logic globalReset,
  wdv_if.dev link
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic rcSync;
  logic brownSync;
  logic highSync;
  logic lowSync;
  logic rcPrev_r;
  logic rcTick;

  wdv_sync #(.WIDTH(4)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .asyncIn({rcOscPin, brownoutPin, highCmpPin, lowCmpPin}),
    .syncOut({rcSync, brownSync, highSync, lowSync})
  );

  // rising edge of the synchronised rc clock is the counter tick
  always_ff @(posedge mclk) begin
    if (reset) begin
      rcPrev_r <= 1'b0;
    end else begin
      rcPrev_r <= rcSync;
    end
  end
  assign rcTick = rcSync & ~rcPrev_r; // [RL4]

  // ****************************************
  // watchdog and power-on sequencer
  // ****************************************
  wdv_state_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic running_r;
  logic [7:0] mode_r;
  logic countEn;
  logic timeout;

  // timeout per tap, in rc ticks
  function automatic logic [CNT_W-1:0] tapLimit(input logic [1:0] sel);
    case (sel)
      2'd0: tapLimit = CNT_W'(TAP0_TICKS - 1); // [RL22]
      2'd1: tapLimit = CNT_W'(TAP1_TICKS - 1);
      2'd2: tapLimit = CNT_W'(TAP2_TICKS - 1);
      default: tapLimit = CNT_W'(TAP3_TICKS - 1);
    endcase
  endfunction : tapLimit

  // halt and stop pause the count unless the mode bits say otherwise
  assign countEn = ~(link.haltMode & ~mode_r[WDM_HALT_BIT]) & // [RL6]
                   ~(link.stopMode & ~mode_r[WDM_STOP_BIT]);  // [RL7]
  // only the two tap bits reach the limit; bits 7:4 go nowhere [RL8]
  assign timeout = running_r & rcTick & countEn &
                   (cnt_r >= tapLimit(mode_r[WDM_TAP_LSB +: 2])); // [RL5]

  // one counter serves the power-on delay and the watchdog
  always_ff @(posedge mclk) begin
    if (reset || brownSync) begin
      state_r <= ST_POR; // [RL12]
      cnt_r <= '0;
    end else begin
      case (state_r)
        ST_POR: begin
          if (rcTick) begin
            if (cnt_r == CNT_W'(POR_TICKS - 1)) begin
              state_r <= ST_RUN;
              cnt_r <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (link.wdtInstr) begin
            cnt_r <= '0; // [RL2]
          end else if (timeout) begin
            state_r <= ST_WDRST; // [RL1]
            cnt_r <= '0;
          end else if (running_r && rcTick && countEn) begin
            cnt_r <= cnt_r + 1'b1; // [RL4]
          end
        end
        ST_WDRST: begin
          // reset pulse is timed in mclk so the cpu sees a clean width
          if (cnt_r == CNT_W'(WDRST_CYC - 1)) begin
            state_r <= ST_RUN;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= ST_POR;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // armed by the first refresh, or at once if the option says so
  always_ff @(posedge mclk) begin
    if (reset || state_r != ST_RUN) begin
      running_r <= WDT_AT_POR; // [RL11]
    end else if (link.wdtInstr) begin
      running_r <= 1'b1; // [RL2]
    end
  end

  assign globalReset = (state_r == ST_POR); // [RL12]
  assign link.cpuReset = (state_r != ST_RUN); // [RL1]

  // ****************************************
  // mode register write window
  // ****************************************
  logic [WIN_CNT_W-1:0] winCnt_r;
  logic stopPrev_r;
  logic winOpen;

  always_ff @(posedge mclk) begin
    if (reset) begin
      stopPrev_r <= 1'b0;
    end else begin
      stopPrev_r <= link.stopMode;
    end
  end

  // reopens after power-on, watchdog reset and leaving stop
  always_ff @(posedge mclk) begin
    if (reset || state_r != ST_RUN || (stopPrev_r && !link.stopMode)) begin
      winCnt_r <= '0; // [RL23]
    end else if (winOpen) begin
      winCnt_r <= winCnt_r + 1'b1;
    end
  end
  assign winOpen = (winCnt_r < WIN_CNT_W'(WIN_CRYSTAL_CLOCK_CLKS)); // [RL9]

  // later writes are dropped silently until a device reset or leaving stop reopens the window
  always_ff @(posedge mclk) begin
    if (reset || state_r != ST_RUN) begin
      mode_r <= WDM_RESET; // [RL7]
    end else if (link.regWr && link.regAddr == REG_WDM_ADDR && winOpen) begin
      mode_r <= link.regWdata; // [RL9]
    end
  end

  // ****************************************
  // voltage detection
  // ****************************************
  logic vdEn_r;
  logic [VD_CNT_W-1:0] vdCnt_r;
  logic vdValid;
  logic highFlag;
  logic lowFlag;
  logic irqLat_r;

  always_ff @(posedge mclk) begin
    if (reset || state_r != ST_RUN) begin
      vdEn_r <= 1'b0; // [RL13]
    end else if (link.regWr && link.regAddr == REG_VD_ADDR) begin
      vdEn_r <= link.regWdata[VD_EN_BIT]; // [RL13]
    end
  end

  // settling time after enable; flags read as zero until it ends
  always_ff @(posedge mclk) begin
    if (reset || !vdEn_r) begin
      vdCnt_r <= '0;
    end else if (!vdValid) begin
      vdCnt_r <= vdCnt_r + 1'b1; // [RL14]
    end
  end
  assign vdValid = (vdCnt_r == VD_CNT_W'(VD_VALID_CYC)); // [RL14]
  assign highFlag = vdEn_r & vdValid & highSync; // [RL15]
  assign lowFlag = vdEn_r & vdValid & lowSync; // [RL16]

  // the low flag sets the request; set wins over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (reset || state_r != ST_RUN) begin
      irqLat_r <= 1'b0;
    end else if (lowFlag) begin
      irqLat_r <= 1'b1; // [RL17]
    end else if (link.irqClear) begin
      irqLat_r <= 1'b0; // [RL17]
    end
  end
  assign link.irqLatched = irqLat_r;
  // masked, the latch is only a flag to poll
  assign link.irqReq = irqLat_r & link.irqMask; // [RL18]

  // ****************************************
  // register reads and refresh flags
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      link.regRdata <= 8'h00;
      link.rdValid <= 1'b0;
    end else begin
      // orders are obeyed only in run, so no answer comes out of reset
      link.rdValid <= link.regRd & (state_r == ST_RUN);
      if (link.regRd && state_r == ST_RUN) begin
        case (link.regAddr)
          REG_VD_ADDR: link.regRdata <= {5'h00, highFlag, lowFlag, vdEn_r};
          REG_WDM_ADDR: link.regRdata <= WDM_READ_VALUE; // [RL10]
          default: link.regRdata <= 8'h00;
        endcase
      end
    end
  end

  // the refresh instruction returns fixed status flags
  always_ff @(posedge mclk) begin
    if (reset) begin
      link.flagUpd <= 1'b0;
      link.flagsZsv <= 3'h0;
    end else begin
      link.flagUpd <= link.wdtInstr & (state_r == ST_RUN); // [RL3]
      if (link.wdtInstr && state_r == ST_RUN) begin
        link.flagsZsv <= WDT_FLAGS_ZSV; // [RL3]
      end
    end
  end

endmodule : wdv_device
`default_nettype wire

// ==== design/wdv_host.sv ====
// cpu-side end: apb registers turned into link orders and status
// assumes an apb master on mclk; answers with zero wait states
`timescale 1ns/1ps
`default_nettype none
module wdv_host import wdv_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  wdv_if.cpu link
);

  // ****************************************
  // apb decode
  // ****************************************
  logic setupPh;
  logic accessPh;
  logic mapped;
  logic wrCtrl;
  logic wrCmd;

  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable;
  assign mapped = (paddr == APB_CTRL) | (paddr == APB_CMD) |
                  (paddr == APB_STAT);
  assign pready = 1'b1;
  assign pslverr = accessPh & ~mapped;
  assign wrCtrl = accessPh & pwrite & (paddr == APB_CTRL);
  assign wrCmd = accessPh & pwrite & (paddr == APB_CMD);

  // ****************************************
  // control levels and pulses
  // ****************************************
  logic haltReq_r;
  logic stopReq_r;
  logic mask_r;
  logic vdShadow_r;
  logic [VD_CNT_W-1:0] vdCnt_r;
  logic vdReady;
  logic [7:0] rdData_r;

  // a device reset also drops the cpu out of halt and stop
  always_ff @(posedge mclk) begin
    if (reset || link.cpuReset) begin
      haltReq_r <= 1'b0;
      stopReq_r <= 1'b0;
    end else if (wrCtrl) begin
      haltReq_r <= pwdata[CTL_HALT];
      stopReq_r <= pwdata[CTL_STOP];
    end
  end

  // mask is its own level, so it can be raised before detection
  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_r <= 1'b0;
    end else if (wrCtrl) begin
      mask_r <= pwdata[CTL_MASK]; // [RL21]
    end
  end

  // single-cycle orders to the device
  always_ff @(posedge mclk) begin
    if (reset) begin
      link.wdtInstr <= 1'b0;
      link.irqClear <= 1'b0;
      link.regWr <= 1'b0;
      link.regRd <= 1'b0;
      link.regAddr <= 8'h00;
      link.regWdata <= 8'h00;
    end else begin
      link.wdtInstr <= wrCtrl & pwdata[CTL_REFRESH]; // [RL2]
      link.irqClear <= wrCtrl & pwdata[CTL_IRQCLR];
      link.regWr <= wrCmd & ~pwdata[CMD_READ_BIT];
      link.regRd <= wrCmd & pwdata[CMD_READ_BIT];
      if (wrCmd) begin
        link.regAddr <= pwdata[15:8];
        link.regWdata <= pwdata[7:0];
      end
    end
  end

  // copy of the detect enable, to keep stop away from live detection
  always_ff @(posedge mclk) begin
    if (reset || link.cpuReset) begin
      vdShadow_r <= 1'b0;
    end else if (wrCmd && !pwdata[CMD_READ_BIT] &&
                 pwdata[15:8] == REG_VD_ADDR) begin
      vdShadow_r <= pwdata[VD_EN_BIT];
    end
  end

  // stop is held off while detection is on [RL19]
  assign link.stopMode = stopReq_r & ~vdShadow_r; // [RL19]
  assign link.haltMode = haltReq_r;
  assign link.irqMask = mask_r;
  // no port mode register lives here, so none can disturb a check [RL20]

  // flags are trusted only once the settling time has passed
  always_ff @(posedge mclk) begin
    if (reset || !vdShadow_r) begin
      vdCnt_r <= '0;
    end else if (!vdReady) begin
      vdCnt_r <= vdCnt_r + 1'b1; // [RL14]
    end
  end
  assign vdReady = (vdCnt_r == VD_CNT_W'(VD_VALID_CYC));

  // ****************************************
  // read data capture and apb read mux
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdData_r <= 8'h00;
    end else if (link.rdValid) begin
      rdData_r <= link.regRdata;
    end
  end

  // read data is registered in the setup cycle, valid in access
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        APB_CTRL: begin
          prdata[CTL_HALT] <= haltReq_r;
          prdata[CTL_STOP] <= stopReq_r;
          prdata[CTL_MASK] <= mask_r;
        end
        APB_STAT: begin
          prdata[7:0] <= rdData_r;
          prdata[STAT_RESET_BIT] <= link.cpuReset;
          prdata[STAT_IRQLAT_BIT] <= link.irqLatched;
          prdata[STAT_IRQREQ_BIT] <= link.irqReq;
          prdata[STAT_FLAGS_LSB +: 3] <= link.flagsZsv;
          prdata[STAT_VDREADY_BIT] <= vdReady;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : wdv_host
`default_nettype wire

// ==== design/wdv_if.sv ====
// link between the supervisor device and the cpu-side controller
// assumes both ends run on the same mclk; no clocking block
`timescale 1ns/1ps
`default_nettype none
interface wdv_if;
  logic wdtInstr;           // refresh instruction, one-cycle pulse
  logic flagUpd;            // flags below are fresh, one-cycle pulse
  logic [2:0] flagsZsv;     // zero, sign, overflow from the refresh
  logic regWr;              // register write pulse
  logic regRd;              // register read pulse
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic rdValid;            // read data valid, one cycle after regRd
  logic haltMode;
  logic stopMode;
  logic irqMask;            // mask bit of the low-voltage interrupt
  logic irqClear;           // clears the latched request, pulse
  logic irqLatched;
  logic irqReq;
  logic cpuReset;           // device holds the cpu in reset

  modport dev (
    input wdtInstr, regWr, regRd, regAddr, regWdata, haltMode,
    input stopMode, irqMask, irqClear,
    output flagUpd, flagsZsv, regRdata, rdValid, irqLatched, irqReq,
    output cpuReset
  );
  modport cpu (
    output wdtInstr, regWr, regRd, regAddr, regWdata, haltMode,
    output stopMode, irqMask, irqClear,
    input flagUpd, flagsZsv, regRdata, rdValid, irqLatched, irqReq,
    input cpuReset
  );
endinterface : wdv_if
`default_nettype wire

// ==== design/wdv_pkg.sv ====
// shared constants and types of the watchdog / voltage supervisor pair
// assumes a single 200 MHz clock, called mclk, on both ends
package wdv_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int MCLK_MHZ = 200;
  // monitor flags settle this long after enable (least time, rounded up)
  localparam int VD_VALID_NS = 20000;
  localparam int VD_VALID_CYC = (VD_VALID_NS * MCLK_MHZ + 999) / 1000;
  localparam int VD_CNT_W = 13;
  // mode register write window, in crystal (mclk) clocks
  localparam int WIN_CRYSTAL_CLOCK_CLKS = 120;
  localparam int WIN_CNT_W = 8;
  // shared watchdog / power-on counter width
  localparam int CNT_W = 16;
  // defaults of the device parameters, counted in rc ticks or mclk
  localparam int POR_RC_TICKS = 64;
  localparam int WDRST_CYCLES = 16;
  localparam int TAP0_RC_TICKS = 256;
  localparam int TAP1_RC_TICKS = 512;
  localparam int TAP2_RC_TICKS = 1024;
  localparam int TAP3_RC_TICKS = 4096;

  // ****************************************
  // device register map
  // ****************************************
  localparam logic [7:0] REG_VD_ADDR = 8'h0c;
  localparam logic [7:0] REG_WDM_ADDR = 8'h0f;
  localparam logic [7:0] WDM_RESET = 8'h08;
  localparam int WDM_TAP_LSB = 0;
  localparam int WDM_HALT_BIT = 2;
  localparam int WDM_STOP_BIT = 3;
  localparam int VD_EN_BIT = 0;
  localparam logic [7:0] WDM_READ_VALUE = 8'h00;
  // zero, sign, overflow values returned by the refresh instruction
  localparam logic [2:0] WDT_FLAGS_ZSV = 3'h4;

  // ****************************************
  // controller registers on apb
  // ****************************************
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_CMD = 12'h004;
  localparam logic [11:0] APB_STAT = 12'h008;
  localparam int CTL_HALT = 0;
  localparam int CTL_STOP = 1;
  localparam int CTL_MASK = 2;
  localparam int CTL_REFRESH = 8;
  localparam int CTL_IRQCLR = 9;
  localparam int CMD_READ_BIT = 16;
  localparam int STAT_RESET_BIT = 8;
  localparam int STAT_IRQLAT_BIT = 9;
  localparam int STAT_IRQREQ_BIT = 10;
  localparam int STAT_FLAGS_LSB = 11;
  localparam int STAT_VDREADY_BIT = 14;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_RUN = 2'b01,
    ST_WDRST = 2'b11
  } wdv_state_e;

endpackage : wdv_pkg

// ==== design/wdv_sync.sv ====
// two-flop synchroniser for pins that come from outside mclk
// assumes the inputs are slow levels; no pulse shorter than 2 clocks
`timescale 1ns/1ps
`default_nettype none
module wdv_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_r <= '0;
      syncOut <= '0;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule : wdv_sync
`default_nettype wire
